/* File: src/irtp_top.v */
`timescale 1ns/100ps
`default_nettype none
`include "irtp_map.vh"
module irtp_top #(
  parameter W16 = `IRTP_W16,
  parameter W8  = `IRTP_W8,
  parameter NCH = `IRTP_NCH16
) (
  input  wire                    SYS_CLK,
  input  wire                    SRST,
  // wide timer configuration
  input  wire [`IRTP_MODE_W-1:0] WIDE_MODE,
  input  wire [`IRTP_DIV_W-1:0]  WIDE_DIV,
  input  wire [W16-1:0]          WIDE_PERIOD,
  input  wire [NCH*W16-1:0]      WIDE_CMP,
  input  wire [NCH-1:0]          WIDE_CAP_MODE,
  input  wire [NCH-1:0]          WIDE_PWM_INIT,
  input  wire                    WIDE_EV_IN,
  input  wire [NCH-1:0]          WIDE_CH_IN,
  input  wire                    IR_MODE,
  // narrow timers configuration, timer a then b packed low to high
  input  wire [2*`IRTP_MODE_W-1:0] NAR_MODE,
  input  wire [2*`IRTP_DIV_W-1:0]  NAR_DIV,
  input  wire [2*W8-1:0]         NAR_PERIOD,
  input  wire [2*W8-1:0]         NAR_CMP,
  input  wire [1:0]              NAR_PWM_INIT,
  input  wire [1:0]              NAR_EV_IN,
  // pin location select per timer: bit0 wide, bit1 narrow a, bit2 narrow b
  input  wire [2:0]              LOC_SEL,
  // status
  output reg  [W16-1:0]          WIDE_COUNT,
  output reg  [NCH*W16-1:0]      WIDE_CAPTURE,
  output reg  [NCH-1:0]          WIDE_CAP_FLAG,
  output reg                     WIDE_WRAP,
  output wire [2*W8-1:0]         NAR_COUNT,
  output reg  [1:0]              NAR_WRAP,
  // pins: location 0 and 1
  output reg  [NCH-1:0]          WIDE_PIN_LOC0,
  output reg  [NCH-1:0]          WIDE_PIN_LOC1,
  output reg  [1:0]              NAR_PIN_LOC0,
  output reg  [1:0]              NAR_PIN_LOC1,
  output reg                     IR_OUT
);
  wire [1:0]      nar_wrap;
  wire [1:0]      nar_pwm;
  wire            tick_p;
  wire            step;
  wire            run;
  wire            wrap;
  reg  [NCH-1:0]  pwm_q;
  reg  [NCH-1:0]  ch_in_q;
  reg  [NCH-1:0]  ch_out;
  wire [NCH-1:0]  ch_edge;

  // the two narrow timers share one module
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_nar
      irtp_ctr8 #(.W(W8)) u_ctr8 (
        .clk      (SYS_CLK),
        .srst     (SRST),
        .mode     (NAR_MODE[g*`IRTP_MODE_W +: `IRTP_MODE_W]),
        .div      (NAR_DIV[g*`IRTP_DIV_W +: `IRTP_DIV_W]),
        .period   (NAR_PERIOD[g*W8 +: W8]),
        .cmp      (NAR_CMP[g*W8 +: W8]),
        .pwm_init (NAR_PWM_INIT[g]),
        .ev_in    (NAR_EV_IN[g]),
        .count    (NAR_COUNT[g*W8 +: W8]),
        .wrap     (nar_wrap[g]),
        .pwm      (nar_pwm[g])
      );
    end
  endgenerate

  assign run = (WIDE_MODE != `IRTP_MODE_STOP);

  // wide prescaler only runs in timer mode and outside infrared mode
  irtp_presc u_presc (
    .clk  (SYS_CLK),
    .srst (SRST),
    .en   ((WIDE_MODE == `IRTP_MODE_TIMER) && !IR_MODE),
    .div  (WIDE_DIV),
    .tick (tick_p)
  );

  // step source: carrier periods, input events or prescaled ticks
  assign step = IR_MODE ? nar_wrap[0] :
                (WIDE_MODE == `IRTP_MODE_EVENT) ? WIDE_EV_IN : tick_p;
  assign wrap = run && step && (WIDE_COUNT == WIDE_PERIOD);

  // wide counter
  always @(posedge SYS_CLK) begin
    if (SRST || !run) begin
      WIDE_COUNT <= {W16{1'b0}};
    end else if (wrap) begin
      WIDE_COUNT <= {W16{1'b0}};
    end else if (step) begin
      WIDE_COUNT <= WIDE_COUNT + 16'h0001;
    end
  end

  // registered period-complete pulses for chaining observers
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      WIDE_WRAP <= 1'b0;
      NAR_WRAP  <= 2'h0;
    end else begin
      WIDE_WRAP <= wrap;
      NAR_WRAP  <= nar_wrap;
    end
  end

  // input edge detect; inputs are synchronous so one register stage suffices
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      ch_in_q <= {NCH{1'b0}};
    end else begin
      ch_in_q <= WIDE_CH_IN;
    end
  end
  assign ch_edge = WIDE_CH_IN ^ ch_in_q;

  // five channels: pwm or capture, chosen per channel
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      always @(posedge SYS_CLK) begin
        if (SRST || !run || WIDE_CAP_MODE[g]) begin
          pwm_q[g] <= WIDE_PWM_INIT[g];
        end else if (wrap) begin
          pwm_q[g] <= WIDE_PWM_INIT[g];
        end else if (step && (WIDE_COUNT == WIDE_CMP[g*W16 +: W16])) begin
          pwm_q[g] <= ~WIDE_PWM_INIT[g];
        end
      end
      // capture latches the count on any edge; flag sticks until reset
      always @(posedge SYS_CLK) begin
        if (SRST) begin
          WIDE_CAPTURE[g*W16 +: W16] <= `IRTP_RST_CMP16;
          WIDE_CAP_FLAG[g]           <= 1'b0;
        end else if (WIDE_CAP_MODE[g] && ch_edge[g]) begin
          WIDE_CAPTURE[g*W16 +: W16] <= WIDE_COUNT;
          WIDE_CAP_FLAG[g]           <= 1'b1;
        end
      end
    end
  endgenerate

  // channel outputs toward pins; capture channels show their init level
  always @* begin
    ch_out = pwm_q;
  end

  // modulated carrier: channel 0 gated by the first narrow timer
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      IR_OUT <= 1'b0;
    end else begin
      IR_OUT <= IR_MODE & pwm_q[0] & nar_pwm[0];
    end
  end

  // pin routing: unselected location stays low
  always @(posedge SYS_CLK) begin
    if (SRST) begin
      WIDE_PIN_LOC0 <= {NCH{1'b0}};
      WIDE_PIN_LOC1 <= {NCH{1'b0}};
      NAR_PIN_LOC0  <= 2'h0;
      NAR_PIN_LOC1  <= 2'h0;
    end else begin
      WIDE_PIN_LOC0 <= LOC_SEL[0] ? {NCH{1'b0}} : ch_out;
      WIDE_PIN_LOC1 <= LOC_SEL[0] ? ch_out : {NCH{1'b0}};
      NAR_PIN_LOC0  <= nar_pwm & ~LOC_SEL[2:1];
      NAR_PIN_LOC1  <= nar_pwm & LOC_SEL[2:1];
    end
  end
endmodule // irtp_top
`default_nettype wire

/* File: src/irtp_map.vh */
`ifndef IRTP_MAP_VH
`define IRTP_MAP_VH
// counter widths
`define IRTP_W16            16
`define IRTP_W8             8
`define IRTP_NCH16          5
// prescaler field: divide by 2**div, div is 3 bits
`define IRTP_DIV_W          3
// counter modes
`define IRTP_MODE_W         2
`define IRTP_MODE_STOP      2'h0
`define IRTP_MODE_TIMER     2'h1
`define IRTP_MODE_EVENT     2'h2
// reset values
`define IRTP_RST_PERIOD16   16'hffff
`define IRTP_RST_PERIOD8    8'hff
`define IRTP_RST_CMP16      16'h0000
`define IRTP_RST_CMP8       8'h00
`endif

/* File: src/irtp_presc.v */
`timescale 1ns/100ps
`default_nettype none
`include "irtp_map.vh"
// prescaler: tick once every 2**div cycles while enabled
module irtp_presc #(
  parameter DW = 7
) (
  input  wire                   clk,
  input  wire                   srst,
  input  wire                   en,
  input  wire [`IRTP_DIV_W-1:0] div,
  output wire                   tick
);
  reg  [DW-1:0] cnt_q;
  wire [DW-1:0] mask;

  assign mask = (7'h01 << div) - 7'h01;
  assign tick = en && ((cnt_q & mask) == {DW{1'b0}});

  // free-running count, held at zero when disabled so the first tick is immediate
  always @(posedge clk) begin
    if (srst || !en) begin
      cnt_q <= {DW{1'b0}};
    end else begin
      cnt_q <= cnt_q + 7'h01;
    end
  end
endmodule // irtp_presc
`default_nettype wire

/* File: src/irtp_ctr8.v */
`timescale 1ns/100ps
`default_nettype none
`include "irtp_map.vh"
// 8-bit timer with one compare channel
module irtp_ctr8 #(
  parameter W = 8
) (
  input  wire                    clk,
  input  wire                    srst,
  input  wire [`IRTP_MODE_W-1:0] mode,
  input  wire [`IRTP_DIV_W-1:0]  div,
  input  wire [W-1:0]            period,
  input  wire [W-1:0]            cmp,
  input  wire                    pwm_init,
  input  wire                    ev_in,
  output reg  [W-1:0]            count,
  output wire                    wrap,
  output reg                     pwm
);
  wire tick_p;
  wire step;
  wire run;

  assign run = (mode != `IRTP_MODE_STOP);

  irtp_presc u_presc (
    .clk  (clk),
    .srst (srst),
    .en   (mode == `IRTP_MODE_TIMER),
    .div  (div),
    .tick (tick_p)
  );

  // event mode counts input pulses, timer mode counts prescaled ticks
  assign step = (mode == `IRTP_MODE_EVENT) ? ev_in : tick_p;
  assign wrap = run && step && (count == period);

  // counter restarts from zero after reaching the period
  always @(posedge clk) begin
    if (srst || !run) begin
      count <= {W{1'b0}};
    end else if (wrap) begin
      count <= {W{1'b0}};
    end else if (step) begin
      count <= count + 8'h01;
    end
  end

  // pwm: flips on compare, back to initial level at period start
  always @(posedge clk) begin
    if (srst || !run) begin
      pwm <= pwm_init;
    end else if (wrap) begin
      pwm <= pwm_init;
    end else if (step && (count == cmp)) begin
      pwm <= ~pwm_init;
    end
  end
endmodule // irtp_ctr8
`default_nettype wire

/* File: verif/irtp_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module irtp_sva #(
  parameter W16 = 16,
  parameter W8  = 8,
  parameter NCH = 5
) (
  input wire logic               SYS_CLK,
  input wire logic               SRST,
  input wire logic [1:0]         WIDE_MODE,
  input wire logic [2:0]         WIDE_DIV,
  input wire logic [W16-1:0]     WIDE_PERIOD,
  input wire logic               IR_MODE,
  input wire logic [3:0]         NAR_MODE,
  input wire logic [5:0]         NAR_DIV,
  input wire logic [2*W8-1:0]    NAR_PERIOD,
  input wire logic [2:0]         LOC_SEL,
  input wire logic [W16-1:0]     WIDE_COUNT,
  input wire logic [NCH-1:0]     WIDE_CAP_FLAG,
  input wire logic               WIDE_WRAP,
  input wire logic [2*W8-1:0]    NAR_COUNT,
  input wire logic [NCH-1:0]     WIDE_PIN_LOC0,
  input wire logic [NCH-1:0]     WIDE_PIN_LOC1,
  input wire logic [1:0]         NAR_PIN_LOC0,
  input wire logic [1:0]         NAR_PIN_LOC1,
  input wire logic               IR_OUT
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (SRST);
  // full-rate stepping only; prescaled and chained steps are judged by the bench
  wire wrun = WIDE_MODE == 2'h1 && WIDE_DIV == 3'h0 && !IR_MODE;
  wire nrun = NAR_MODE[1:0] == 2'h1 && NAR_DIV[2:0] == 3'h0;
  a_wide_step:
    assert property (wrun && WIDE_COUNT < WIDE_PERIOD |=> WIDE_COUNT == $past(WIDE_COUNT) + 1'b1)
    else $error("wide count did not step");
  a_wide_wrap:
    assert property (wrun && WIDE_COUNT == WIDE_PERIOD |=> WIDE_COUNT == '0 ##[0:1] WIDE_WRAP)
    else $error("wide wrap missing");
  a_wrap_pulse:
    assert property (WIDE_WRAP && wrun && WIDE_PERIOD != '0 |=> !WIDE_WRAP)
    else $error("wide wrap longer than one cycle");
  a_nar_step:
    assert property (nrun && NAR_COUNT[7:0] < NAR_PERIOD[7:0]
                     |=> NAR_COUNT[7:0] == $past(NAR_COUNT[7:0]) + 1'b1)
    else $error("narrow count did not step");
  a_wide_stop:
    assert property (WIDE_MODE == 2'h0 |=> WIDE_COUNT == '0)
    else $error("stop did not clear wide count");
  a_ir_gate:
    assert property (IR_OUT == ($past(IR_MODE) & (WIDE_PIN_LOC0[0] | WIDE_PIN_LOC1[0])
                                & (NAR_PIN_LOC0[0] | NAR_PIN_LOC1[0])))
    else $error("ir output not the gated carrier");
  a_wide_loc:
    assert property (($past(LOC_SEL[0]) ? WIDE_PIN_LOC0 : WIDE_PIN_LOC1) == '0)
    else $error("wide pin active at unselected location");
  a_nar_loc:
    assert property (($past(LOC_SEL[1]) ? NAR_PIN_LOC0[0] : NAR_PIN_LOC1[0]) == 1'b0
                     && ($past(LOC_SEL[2]) ? NAR_PIN_LOC0[1] : NAR_PIN_LOC1[1]) == 1'b0)
    else $error("narrow pin active at unselected location");
  a_flag_sticky:
    assert property ((WIDE_CAP_FLAG & $past(WIDE_CAP_FLAG)) == $past(WIDE_CAP_FLAG))
    else $error("capture flag dropped");
  c_wrap: cover property (WIDE_WRAP);
  c_ir:   cover property (IR_OUT);
  c_cap:  cover property (|WIDE_CAP_FLAG);
endmodule // irtp_sva
`default_nettype wire

/* File: verif/irtp_load.sv */
`timescale 1ns/100ps
`default_nettype none
// emitter load: counts the cycles the carrier lights it
module irtp_load (
  input wire logic        clk,
  input wire logic        drive,
  output var logic [15:0] on_cycles
);
  initial on_cycles = 16'h0000;
  always @(posedge clk) if (drive === 1'b1) on_cycles <= on_cycles + 16'h0001;
endmodule // irtp_load
`default_nettype wire

/* File: verif/irtp_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`include "irtp_map.vh"
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin fail_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module irtp_top_tb;
  logic        SYS_CLK = 1'b0, SRST = 1'b1, IR_MODE = 1'b0, WIDE_EV_IN = 1'b0;
  logic [1:0]  WIDE_MODE = `IRTP_MODE_STOP, NAR_PWM_INIT = 2'h0, NAR_EV_IN = 2'h0;
  logic [2:0]  WIDE_DIV = 3'h0, LOC_SEL = 3'h0;
  logic [3:0]  NAR_MODE = 4'h0;
  logic [5:0]  NAR_DIV = 6'h00;
  logic [4:0]  WIDE_CAP_MODE = 5'h02, WIDE_PWM_INIT = 5'h00, WIDE_CH_IN = 5'h00;
  logic [15:0] WIDE_PERIOD = 16'h0004, NAR_PERIOD = 16'h0404, NAR_CMP = 16'h0101;
  logic [79:0] WIDE_CMP = {5{16'h0001}}, WIDE_CAPTURE;
  logic [15:0] WIDE_COUNT, NAR_COUNT, ir_on, snap;
  logic [4:0]  WIDE_CAP_FLAG, WIDE_PIN_LOC0, WIDE_PIN_LOC1;
  logic [1:0]  NAR_WRAP, NAR_PIN_LOC0, NAR_PIN_LOC1;
  logic        WIDE_WRAP, IR_OUT;
  int          fail_count = 0, n_checks = 0;
  irtp_top uut (.SYS_CLK, .SRST, .WIDE_MODE, .WIDE_DIV, .WIDE_PERIOD, .WIDE_CMP, .WIDE_CAP_MODE,
    .WIDE_PWM_INIT, .WIDE_EV_IN, .WIDE_CH_IN, .IR_MODE, .NAR_MODE, .NAR_DIV, .NAR_PERIOD,
    .NAR_CMP, .NAR_PWM_INIT, .NAR_EV_IN, .LOC_SEL, .WIDE_COUNT, .WIDE_CAPTURE, .WIDE_CAP_FLAG,
    .WIDE_WRAP, .NAR_COUNT, .NAR_WRAP, .WIDE_PIN_LOC0, .WIDE_PIN_LOC1, .NAR_PIN_LOC0,
    .NAR_PIN_LOC1, .IR_OUT);
  irtp_load u_load (.clk(SYS_CLK), .drive(IR_OUT), .on_cycles(ir_on));
  initial forever #4 SYS_CLK = ~SYS_CLK;
  task cyc(input int n); repeat (n) @(negedge SYS_CLK); endtask
  // stop mode restarts counts from zero without asserting reset
  task restart; WIDE_MODE = `IRTP_MODE_STOP; NAR_MODE = 4'h0; cyc(1); endtask
  // period 4, compare 1: pins high while count is 3, 4 and the following 0
  task t_pwm(input logic loc);
    int c;
    logic e;
    restart();
    LOC_SEL = {loc, loc, loc};
    WIDE_MODE = `IRTP_MODE_TIMER;
    NAR_MODE = 4'h5;
    for (int k = 1; k <= 15; k++) begin
      cyc(1);
      c = k % 5;
      e = c >= 3 || c == 0;
      `CHK("wide_count", c[15:0], WIDE_COUNT)
      `CHK("nar_b_count", c[7:0], NAR_COUNT[15:8])
      `CHK("wide_pin", e, loc ? WIDE_PIN_LOC1[0] : WIDE_PIN_LOC0[0])
      `CHK("nar_b_pin", e, loc ? NAR_PIN_LOC1[1] : NAR_PIN_LOC0[1])
      `CHK("wide_wrap", c == 0, WIDE_WRAP)
      `CHK("nar_wrap", (c == 0) ? 2'h3 : 2'h0, NAR_WRAP)
    end
  endtask
  // both edges capture; the count at the edge where the input change is first seen is kept
  task t_cap;
    restart();
    WIDE_MODE = `IRTP_MODE_TIMER;
    WIDE_PERIOD = 16'h00ff;
    cyc(20);
    for (int k = 0; k < 2; k++) begin
      snap = WIDE_COUNT;
      WIDE_CH_IN = {3'h0, ~WIDE_CH_IN[1], 1'b0};
      cyc(3);
      `CHK("cap_flag", 1'b1, WIDE_CAP_FLAG[1])
      `CHK("cap_value", snap, WIDE_CAPTURE[31:16])
    end
    `CHK("cap_pin", 1'b0, WIDE_PIN_LOC0[1] | WIDE_PIN_LOC1[1])
    `CHK("cap_idle", 1'b0, WIDE_CAP_FLAG[2])
  endtask
  task t_evt;
    restart();
    WIDE_MODE = `IRTP_MODE_EVENT;
    NAR_MODE = 4'h2;
    WIDE_EV_IN = 1'b1;
    NAR_EV_IN = 2'h1;
    cyc(3);
    WIDE_EV_IN = 1'b0;
    NAR_EV_IN = 2'h0;
    cyc(3);
    `CHK("event_wide", 16'h0003, WIDE_COUNT)
    `CHK("event_nar", 8'h03, NAR_COUNT[7:0])
  endtask
  // divide by 4: ticks at the first timer cycle, then every fourth
  task t_div;
    restart();
    WIDE_DIV = 3'h2;
    NAR_DIV = 6'h02;
    WIDE_MODE = `IRTP_MODE_TIMER;
    NAR_MODE = 4'h1;
    cyc(9);
    `CHK("div_wide", 16'h0003, WIDE_COUNT)
    `CHK("div_nar", 8'h03, NAR_COUNT[7:0])
    WIDE_DIV = 3'h0;
    NAR_DIV = 6'h00;
  endtask
  // carrier period 4 cycles; wide counts carrier periods, not clocks
  task t_ir;
    restart();
    NAR_PERIOD = 16'h0403;
    WIDE_PERIOD = 16'h0002;
    WIDE_CMP[15:0] = 16'h0000;
    IR_MODE = 1'b1;
    WIDE_MODE = `IRTP_MODE_TIMER;
    NAR_MODE = 4'h1;
    snap = ir_on;
    cyc(10);
    `CHK("ir_count", 16'h0002, WIDE_COUNT)
    `CHK("ir_lit", 1'b1, ir_on > snap)
    IR_MODE = 1'b0;
    cyc(2);
    snap = ir_on;
    cyc(12);
    `CHK("ir_dark", snap, ir_on)
  endtask
  task tally_and_finish;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    cyc(4);
    SRST = 1'b0;
    t_pwm(1'b0);
    t_pwm(1'b1);
    t_cap();
    t_evt();
    t_div();
    t_ir();
    tally_and_finish();
  end
  // the sequence needs about 105 cycles
  initial begin
    #20000;
    fail_count++;
    tally_and_finish();
  end
endmodule // irtp_top_tb
bind irtp_top irtp_sva #(.W16(W16), .W8(W8), .NCH(NCH)) u_sva (.SYS_CLK, .SRST, .WIDE_MODE,
  .WIDE_DIV, .WIDE_PERIOD, .IR_MODE, .NAR_MODE, .NAR_DIV, .NAR_PERIOD, .LOC_SEL, .WIDE_COUNT,
  .WIDE_CAP_FLAG, .WIDE_WRAP, .NAR_COUNT, .WIDE_PIN_LOC0, .WIDE_PIN_LOC1, .NAR_PIN_LOC0,
  .NAR_PIN_LOC1, .IR_OUT);
`default_nettype wire
